// >>> bench/dual_watchdog_timer_tb.sv
// self-checking testbench of the dual watchdog timer
`timescale 1ns/1ps
module dual_watchdog_timer_tb;
  // ----------------------------------------------------------------
  // stimulus, observed outputs and counters
  // ----------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [5:0]  adr   = 6'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic        wdclk = 1'b0;
  logic [1:0]  dphase = 2'h0;
  logic        lp    = 1'b0;
  logic        brk   = 1'b0;
  logic [1:0]  auto  = 2'b00;
  logic [7:0]  mcfg  = 8'h10;
  logic [7:0]  icfg  = 8'h10;
  logic [15:0] ito   = 16'hffff;
  logic [31:0] rdat, q, q2;
  logic        ack, mrst, irst, nmi, irq, evl, scs;
  logic [3:0]  seen;
  int          err_total = 0;
  int          n_tests   = 0;
  int          cycles    = 0;
  localparam logic [5:0] ib   = dual_watchdog_pkg::CH_STRIDE;
  localparam logic [5:0] cfg  = dual_watchdog_pkg::SUB_CONFIG;
  localparam logic [5:0] cnt  = dual_watchdog_pkg::SUB_COUNT;
  localparam logic [5:0] stat = dual_watchdog_pkg::OFS_STATUS;

  // main clock 250 MHz; count source toggles every third edge, 3 high 3 low
  always #2 clock = ~clock;
  always @(posedge clock) begin
    if (dphase == 2'h2) begin
      dphase <= 2'h0;
      wdclk  <= ~wdclk;
    end else begin
      dphase <= dphase + 2'h1;
    end
  end

  dual_watchdog_timer i_dual_watchdog_timer (
    .i_clock(clock), .i_rst(rst), .i_clk_en(1'b1),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_dedicated_watchdog_clock(wdclk), .i_low_power(lp), .i_debug_break(brk),
    .i_osm_auto_start(auto), .i_osm_main_cfg(mcfg), .i_osm_ind_cfg(icfg),
    .i_osm_main_timeout(16'hffff), .i_osm_ind_timeout(ito),
    .i_osm_main_window(32'hffff_0000), .i_osm_ind_window(32'hffff_0000),
    .o_main_reset(mrst), .o_ind_reset(irst), .o_nmi(nmi), .o_irq(irq),
    .o_event_link(evl), .o_sleep_count_stop(scs)
  );

  // ----------------------------------------------------------------
  // bus cycles and comparisons
  // ----------------------------------------------------------------
  // classic cycle: request held until ack is sampled, released at that edge
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do @(posedge clock); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    wb(1'b1, a, d, dummy);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, r);
  endtask : rd

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // level outputs are looked at mid-cycle, after the edge's updates landed
  task automatic chk_pin(input logic g, input logic e);
    @(negedge clock);
    chk({31'h0, g}, {31'h0, e});
  endtask : chk_pin

  task automatic refresh(input logic [5:0] base);
    wr(base, {16'h0, dual_watchdog_pkg::REFRESH_KEY});
  endtask : refresh

  // collects pulses {nmi, event link, ind reset, main reset} up to a bound
  task automatic watch(input int lim);
    int n;
    seen = 4'h0;
    n = 0;
    while (seen == 4'h0 && n < lim) begin
      @(negedge clock);
      seen = seen | {nmi, evl, irst, mrst};
      n++;
    end
    @(negedge clock);
    seen = seen | {nmi, evl, irst, mrst};
  endtask : watch

  task automatic do_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : do_reset

  // main count must hold while stopped and move again once released
  task automatic freeze(input logic use_brk);
    @(posedge clock);
    lp  <= ~use_brk;
    brk <= use_brk;
    repeat (2) @(posedge clock);
    rd(cnt, q);
    repeat (40) @(posedge clock);
    rd(cnt, q2);
    chk(q2, q);
    lp  <= 1'b0;
    brk <= 1'b0;
    repeat (40) @(posedge clock);
    rd(cnt, q2);
    chk({31'h0, q2[15:0] != q[15:0]}, 32'h1);
  endtask : freeze

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    rd(cfg, q);
    chk(q, {24'h0, dual_watchdog_pkg::CFG_RESET});
    rd(dual_watchdog_pkg::SUB_TIMEOUT, q);
    chk(q, {16'h0, dual_watchdog_pkg::TIMEOUT_RESET});
    rd(ib + dual_watchdog_pkg::SUB_WINDOW, q);
    chk(q, dual_watchdog_pkg::WINDOW_RESET);
    rd(6'h3c, q);
    chk(q, 32'h0);
    chk_pin(scs, 1'b1);
    // register start: divide-by-64 prescaler, refresh permitted only at or below 0x80
    wr(cfg, 32'h01);
    wr(dual_watchdog_pkg::SUB_TIMEOUT, 32'h1000);
    wr(dual_watchdog_pkg::SUB_WINDOW, 32'h0080_0000);
    repeat (100) @(posedge clock);
    rd(cnt, q);
    chk({30'h0, q[17:16]}, 32'h0);
    refresh(6'h00);
    rd(cnt, q);
    chk({31'h0, q[17:0] == 18'h11000 || q[17:0] == 18'h10fff}, 32'h1);
    wr(cfg, 32'h10);
    rd(cfg, q2);
    chk(q2, 32'h01);
    // 640 cycles at a divide of 64 take ten steps off the count
    repeat (640) @(posedge clock);
    rd(cnt, q2);
    chk({31'h0, (q[15:0] - q2[15:0]) inside {16'd9, 16'd10, 16'd11}}, 32'h1);
    refresh(6'h00);
    watch(8);
    chk({28'h0, seen}, 32'h0);
    rd(stat, q);
    chk(q, 32'h2);
    rd(cnt, q);
    chk({30'h0, q[17:16]}, 32'h2);
    chk_pin(irq, 1'b0);
    wr(dual_watchdog_pkg::OFS_ENABLE, 32'h2);
    chk_pin(irq, 1'b1);
    wr(dual_watchdog_pkg::OFS_ENABLE, 32'h0);
    chk_pin(irq, 1'b0);
    wr(dual_watchdog_pkg::OFS_ENABLE, 32'h2);
    wr(dual_watchdog_pkg::OFS_CLEAR, 32'h2);
    rd(stat, q);
    chk(q, 32'h0);
    chk_pin(irq, 1'b0);
    refresh(6'h00);
    rd(cnt, q);
    chk({30'h0, q[17:16]}, 32'h2);
    // independent variant, interrupt side with nmi, underflow after short timeout
    wr(ib + cfg, 32'h20);
    wr(ib + dual_watchdog_pkg::SUB_TIMEOUT, 32'h3);
    refresh(ib);
    watch(200);
    chk({28'h0, seen}, 32'hc);
    rd(stat, q);
    chk(q, 32'h4);
    // auto-start: settings come from option memory, reset output selected
    auto <= 2'b11;
    icfg <= 8'h50;
    ito  <= 16'h0004;
    do_reset();
    rd(cnt, q);
    chk({30'h0, q[17:16]}, 32'h1);
    rd(ib + cnt, q);
    chk({30'h0, q[17:16]}, 32'h1);
    wr(cfg, 32'h00);
    rd(cfg, q);
    chk(q, 32'h10);
    // permitted refresh while running puts the count back at the top
    refresh(6'h00);
    rd(cnt, q);
    chk({31'h0, q[15:0] inside {16'hffff, 16'hfffe}}, 32'h1);
    chk_pin(scs, 1'b0);
    watch(300);
    chk({28'h0, seen}, 32'h2);
    freeze(1'b0);
    freeze(1'b1);
    summarize();
  end
endmodule : dual_watchdog_timer_tb

// >>> rtl/dual_watchdog_pkg.sv
// constants, field layout and types of the dual watchdog timer
// What this block does
// - auto-start mode counts right after reset release
// - register start mode waits for first refresh
// - reset stops; low power stops per variant
// - register start mode halts on underflow/error
// - refresh in prohibited window is refresh error
// - underflow or refresh error gives reset output
// - events selectable as nmi or interrupt instead
// - event link only when reset output not selected (nmi or interrupt)
// - selectable prescalers for each variant
// - software reads both counters any time
// - independent variant signals event link unit
// - independent variant outputs sleep count-stop control
// - software cannot stop a running watchdog
// - debugger break halts both counts
// - settings from option memory or registers
package dual_watchdog_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PRE_W = 13;
  localparam int unsigned NCH   = 2;
  localparam int unsigned MAIN  = 0;
  localparam int unsigned IND   = 1;
  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] CH_STRIDE   = 6'h14;
  localparam logic [5:0] SUB_REFRESH = 6'h00;
  localparam logic [5:0] SUB_CONFIG  = 6'h04;
  localparam logic [5:0] SUB_TIMEOUT = 6'h08;
  localparam logic [5:0] SUB_WINDOW  = 6'h0c;
  localparam logic [5:0] SUB_COUNT   = 6'h10;
  localparam logic [5:0] OFS_STATUS  = 6'h28;
  localparam logic [5:0] OFS_CLEAR   = 6'h2c;
  localparam logic [5:0] OFS_ENABLE  = 6'h30;
  localparam logic [15:0] REFRESH_KEY = 16'ha5a5;
  // ----------------------------------------------------------------
  // config fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CFG_DIV_LSB = 0;
  localparam int unsigned CFG_RST_SEL = 4;
  localparam int unsigned CFG_NMI_SEL = 5;
  localparam int unsigned CFG_LP_RUN  = 6;
  localparam int unsigned WIN_END_LSB = 0;
  localparam int unsigned WIN_BEG_LSB = 16;
  localparam logic [7:0]       CFG_RESET     = 8'h10;
  localparam logic [CNT_W-1:0] TIMEOUT_RESET = 16'hffff;
  localparam logic [31:0]      WINDOW_RESET  = 32'hffff_0000;
  localparam int unsigned ST_UNDER = 0;
  localparam int unsigned ST_RFERR = 1;
  // prescaler shift per select code 0..5, main then independent
  localparam logic [5:0][3:0] MAIN_SHIFTS = {4'hd, 4'hb, 4'h9, 4'h7, 4'h6, 4'h2};
  localparam logic [5:0][3:0] IND_SHIFTS  = {4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h0};
  localparam logic [2:0] DIV_MAX_CODE = 3'h5;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RUN  = 2'b01,
    WD_HALT = 2'b10
  } wd_state_t;

  typedef struct packed {
    wd_state_t        mode;
    logic [CNT_W-1:0] count;
    logic [PRE_W-1:0] pre;
    logic [7:0]       cfg;
    logic [CNT_W-1:0] timeout;
    logic [31:0]      window;
    logic             auto_mode;
  } chan_t;
endpackage : dual_watchdog_pkg

// >>> rtl/dual_watchdog_timer.sv
// dual watchdog timer: main and independent variants with wishbone slave
`timescale 1ns/1ps
module dual_watchdog_timer (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_clk_en,
  // wishbone classic slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [5:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // system side
  input  wire logic        i_dedicated_watchdog_clock,
  input  wire logic        i_low_power,
  input  wire logic        i_debug_break,
  // option setting memory, held stable around reset
  input  wire logic [1:0]  i_osm_auto_start,
  input  wire logic [7:0]  i_osm_main_cfg,
  input  wire logic [7:0]  i_osm_ind_cfg,
  input  wire logic [15:0] i_osm_main_timeout,
  input  wire logic [15:0] i_osm_ind_timeout,
  input  wire logic [31:0] i_osm_main_window,
  input  wire logic [31:0] i_osm_ind_window,
  // outputs
  output logic             o_main_reset,
  output logic             o_ind_reset,
  output logic             o_nmi,
  output logic             o_irq,
  output logic             o_event_link,
  output logic             o_sleep_count_stop
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (dual_watchdog_pkg::CNT_W > 16) begin : g_bad_width
    $error("counter must fit a window half-word");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dual_watchdog_pkg::chan_t [dual_watchdog_pkg::NCH-1:0] ch;
    logic [3:0]  status;
    logic [3:0]  enable;
    logic        loaded;
    logic [2:0]  dclk_sync;
    logic        ack;
    logic [31:0] rdat;
    logic [1:0]  rst_out;
    logic        nmi;
    logic        evt_link;
    logic        irq;
  } state_t;

  state_t st;
  state_t next_st;
  logic [1:0] ev_under;
  logic [1:0] ev_rferr;
  logic [1:0] refresh_hit;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // terminal prescaler value for a select code; bad codes act as the slowest
  function automatic logic [12:0] pre_term(input logic [2:0] code, input logic ind);
    logic [2:0] c;
    logic [3:0] sh;
    c = (code > dual_watchdog_pkg::DIV_MAX_CODE) ? dual_watchdog_pkg::DIV_MAX_CODE : code;
    sh = ind ? dual_watchdog_pkg::IND_SHIFTS[c] : dual_watchdog_pkg::MAIN_SHIFTS[c];
    return 13'((32'h1 << sh) - 32'h1);
  endfunction : pre_term

  // refresh permitted while count lies between window end and window start
  function automatic logic in_window(input logic [15:0] cnt, input logic [31:0] win);
    return (cnt <= win[dual_watchdog_pkg::WIN_BEG_LSB +: 16]) &&
           (cnt >= win[dual_watchdog_pkg::WIN_END_LSB +: 16]);
  endfunction : in_window

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic        req;
    logic        wr;
    logic        dclk_rise;
    logic        tick;
    logic        paused;
    logic [5:0]  base;
    logic [3:0]  set_bits;
    logic [31:0] rd;
    logic [7:0]  osm_cfg;
    req = 1'b0;
    wr = 1'b0;
    dclk_rise = 1'b0;
    tick = 1'b0;
    paused = 1'b0;
    base = 6'h00;
    set_bits = 4'h0;
    rd = 32'h0;
    osm_cfg = 8'h0;
    next_st = st;
    ev_under = 2'b00;
    ev_rferr = 2'b00;
    refresh_hit = 2'b00;
    next_st.ack = 1'b0;
    next_st.rst_out = 2'b00;
    next_st.nmi = 1'b0;
    next_st.evt_link = 1'b0;
    // two flops before the edge detector looks at the dedicated clock
    next_st.dclk_sync = {st.dclk_sync[1:0], i_dedicated_watchdog_clock};
    dclk_rise = st.dclk_sync[1] & ~st.dclk_sync[2];
    // one request per cycle, answered one edge later
    req = i_wb_cyc & i_wb_stb & ~st.ack;
    wr = req & i_wb_we;
    next_st.ack = req;

    if (!st.loaded) begin
      // first edge after reset release: take settings from option memory
      next_st.loaded = 1'b1;
      for (int c = 0; c < 2; c++) begin
        osm_cfg = (c == 0) ? i_osm_main_cfg : i_osm_ind_cfg;
        next_st.ch[c].auto_mode = i_osm_auto_start[c];
        if (i_osm_auto_start[c]) begin
          next_st.ch[c].cfg = osm_cfg;
          next_st.ch[c].timeout = (c == 0) ? i_osm_main_timeout : i_osm_ind_timeout;
          next_st.ch[c].window = (c == 0) ? i_osm_main_window : i_osm_ind_window;
          next_st.ch[c].count = next_st.ch[c].timeout;
          next_st.ch[c].mode = dual_watchdog_pkg::WD_RUN;
        end
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        base = (c == 0) ? 6'h00 : dual_watchdog_pkg::CH_STRIDE;
        refresh_hit[c] = wr && (i_wb_adr == base + dual_watchdog_pkg::SUB_REFRESH) &&
                         (i_wb_dat[15:0] == dual_watchdog_pkg::REFRESH_KEY);
        // main counts every cycle, independent counts dedicated clock edges
        tick = (c == 0) ? 1'b1 : dclk_rise;
        paused = i_debug_break |
                 (i_low_power & ((c == 0) | ~st.ch[c].cfg[dual_watchdog_pkg::CFG_LP_RUN]));
        case (st.ch[c].mode)
          dual_watchdog_pkg::WD_IDLE: begin
            if (refresh_hit[c]) begin
              next_st.ch[c].mode = dual_watchdog_pkg::WD_RUN;
              next_st.ch[c].count = st.ch[c].timeout;
              next_st.ch[c].pre = '0;
            end
          end
          dual_watchdog_pkg::WD_RUN: begin
            // no bus write leaves run; only events in register start mode do
            if (refresh_hit[c]) begin
              if (in_window(st.ch[c].count, st.ch[c].window)) begin
                next_st.ch[c].count = st.ch[c].timeout;
                next_st.ch[c].pre = '0;
              end else begin
                ev_rferr[c] = 1'b1;
              end
            end else if (!paused && tick) begin
              if (st.ch[c].pre >= pre_term(st.ch[c].cfg[2:0], c == 1)) begin
                next_st.ch[c].pre = '0;
                if (st.ch[c].count == '0) begin
                  ev_under[c] = 1'b1;
                end else begin
                  next_st.ch[c].count = st.ch[c].count - 16'h1;
                end
              end else begin
                next_st.ch[c].pre = st.ch[c].pre + 13'h1;
              end
            end
            if (ev_under[c] | ev_rferr[c]) begin
              if (!st.ch[c].auto_mode) begin
                next_st.ch[c].mode = dual_watchdog_pkg::WD_HALT;
              end else begin
                next_st.ch[c].count = st.ch[c].timeout;
                next_st.ch[c].pre = '0;
              end
            end
          end
          dual_watchdog_pkg::WD_HALT: begin
            next_st.ch[c].mode = dual_watchdog_pkg::WD_HALT;
          end
          default: begin
            next_st.ch[c].mode = dual_watchdog_pkg::WD_IDLE;
          end
        endcase
        // route events to reset or to the interrupt side
        if (ev_under[c] | ev_rferr[c]) begin
          if (st.ch[c].cfg[dual_watchdog_pkg::CFG_RST_SEL]) begin
            next_st.rst_out[c] = 1'b1;
          end else begin
            set_bits[2*c + dual_watchdog_pkg::ST_UNDER] = ev_under[c];
            set_bits[2*c + dual_watchdog_pkg::ST_RFERR] = ev_rferr[c];
            next_st.nmi = next_st.nmi | st.ch[c].cfg[dual_watchdog_pkg::CFG_NMI_SEL];
            if (c == 1) begin
              next_st.evt_link = 1'b1;
            end
          end
        end
        // settings only writable in register start mode before counting
        if (wr && !st.ch[c].auto_mode && st.ch[c].mode == dual_watchdog_pkg::WD_IDLE) begin
          if (i_wb_adr == base + dual_watchdog_pkg::SUB_CONFIG) begin
            next_st.ch[c].cfg = 8'(merge({24'h0, st.ch[c].cfg}, i_wb_dat, i_wb_sel));
          end
          if (i_wb_adr == base + dual_watchdog_pkg::SUB_TIMEOUT) begin
            next_st.ch[c].timeout = 16'(merge({16'h0, st.ch[c].timeout}, i_wb_dat, i_wb_sel));
          end
          if (i_wb_adr == base + dual_watchdog_pkg::SUB_WINDOW) begin
            next_st.ch[c].window = merge(st.ch[c].window, i_wb_dat, i_wb_sel);
          end
        end
        // read side for this channel's registers
        if (i_wb_adr == base + dual_watchdog_pkg::SUB_CONFIG) begin
          rd = {24'h0, st.ch[c].cfg};
        end
        if (i_wb_adr == base + dual_watchdog_pkg::SUB_TIMEOUT) begin
          rd = {16'h0, st.ch[c].timeout};
        end
        if (i_wb_adr == base + dual_watchdog_pkg::SUB_WINDOW) begin
          rd = st.ch[c].window;
        end
        if (i_wb_adr == base + dual_watchdog_pkg::SUB_COUNT) begin
          rd = {14'h0, st.ch[c].mode, st.ch[c].count};
        end
      end
    end

    // sticky status: a new event wins over a clear in the same cycle
    next_st.status = st.status;
    if (wr && i_wb_adr == dual_watchdog_pkg::OFS_CLEAR && i_wb_sel[0]) begin
      next_st.status = st.status & ~i_wb_dat[3:0];
    end
    next_st.status = next_st.status | set_bits;
    if (wr && i_wb_adr == dual_watchdog_pkg::OFS_ENABLE) begin
      next_st.enable = 4'(merge({28'h0, st.enable}, i_wb_dat, i_wb_sel));
    end
    if (i_wb_adr == dual_watchdog_pkg::OFS_STATUS) begin
      rd = {28'h0, st.status};
    end
    if (i_wb_adr == dual_watchdog_pkg::OFS_ENABLE) begin
      rd = {28'h0, st.enable};
    end
    // unmapped, refresh and clear read as zero
    if (req && !i_wb_we) begin
      next_st.rdat = rd;
    end
    next_st.irq = |(next_st.status & next_st.enable);
  end

  // ----------------------------------------------------------------
  // state register; clock enable low freezes everything but reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st <= '0;
      for (int c = 0; c < 2; c++) begin
        st.ch[c].mode <= dual_watchdog_pkg::WD_IDLE;
        st.ch[c].cfg <= dual_watchdog_pkg::CFG_RESET;
        st.ch[c].timeout <= dual_watchdog_pkg::TIMEOUT_RESET;
        st.ch[c].window <= dual_watchdog_pkg::WINDOW_RESET;
      end
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_wb_dat = st.rdat;
  assign o_wb_ack = st.ack;
  assign o_main_reset = st.rst_out[dual_watchdog_pkg::MAIN];
  assign o_ind_reset = st.rst_out[dual_watchdog_pkg::IND];
  assign o_nmi = st.nmi;
  assign o_irq = st.irq;
  assign o_event_link = st.evt_link;
  // tells the power controller whether sleep freezes the independent count
  assign o_sleep_count_stop =
    ~st.ch[dual_watchdog_pkg::IND].cfg[dual_watchdog_pkg::CFG_LP_RUN];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst || !i_clk_en);

  chk_auto_start_run: assert property (
    $fell(i_rst) && i_osm_auto_start[0] |-> ##1 st.ch[0].mode == dual_watchdog_pkg::WD_RUN)
    else $error("auto-start main not running after reset");

  chk_idle_waits: assert property (
    st.loaded && st.ch[1].mode == dual_watchdog_pkg::WD_IDLE && !refresh_hit[1]
    |=> st.ch[1].mode == dual_watchdog_pkg::WD_IDLE)
    else $error("idle watchdog started without refresh");

  chk_low_power_freeze: assert property (
    st.loaded && i_low_power && !refresh_hit[0] |=> $stable(st.ch[0].count))
    else $error("main count moved in low power");

  chk_halt_register: assert property (
    (ev_under[0] || ev_rferr[0]) && !st.ch[0].auto_mode
    |=> st.ch[0].mode == dual_watchdog_pkg::WD_HALT [*2])
    else $error("register start main did not halt on event");

  chk_window_error: assert property (
    refresh_hit[0] && st.ch[0].mode == dual_watchdog_pkg::WD_RUN &&
    !in_window(st.ch[0].count, st.ch[0].window) |-> ev_rferr[0])
    else $error("prohibited refresh not flagged");

  chk_reset_output: assert property (
    ev_under[1] && st.ch[1].cfg[dual_watchdog_pkg::CFG_RST_SEL] |=> o_ind_reset ##1 !o_ind_reset)
    else $error("underflow gave no single reset pulse");

  chk_irq_route: assert property (
    ev_rferr[0] && !st.ch[0].cfg[dual_watchdog_pkg::CFG_RST_SEL]
    |=> st.status[dual_watchdog_pkg::ST_RFERR] && !o_main_reset)
    else $error("refresh error not routed to interrupt");

  chk_link_gated: assert property (
    o_event_link |-> !$past(st.ch[1].cfg[dual_watchdog_pkg::CFG_RST_SEL]))
    else $error("event link fired with reset selected");

  chk_no_sw_stop: assert property (
    st.ch[0].mode == dual_watchdog_pkg::WD_RUN && !ev_under[0] && !ev_rferr[0]
    |=> st.ch[0].mode == dual_watchdog_pkg::WD_RUN)
    else $error("running main watchdog stopped");

  chk_break_freeze: assert property (
    st.loaded && i_debug_break && !refresh_hit[1] |=> $stable(st.ch[1].count))
    else $error("independent count moved during break");

  chk_refresh_reload: assert property (
    refresh_hit[0] && st.ch[0].mode == dual_watchdog_pkg::WD_RUN &&
    in_window(st.ch[0].count, st.ch[0].window) |=> st.ch[0].count == $past(st.ch[0].timeout))
    else $error("valid refresh did not reload");

endmodule : dual_watchdog_timer
